// ===== src/cpcsr_pkg.sv
// Package: offsets, field positions, reset values and types of the protection register pair
package cpcsr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] PROTECT_CONTROL_ADDR = 8'hc3;
  localparam logic [7:0] PROTECT_STATUS_ADDR = 8'hc4;

  // Reset values
  localparam logic [7:0] PROTECT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PROTECT_STATUS_RST = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Control field positions
  localparam int CTL_TX_RESET = 7;
  localparam int CTL_RESERVED = 6;
  localparam int CTL_LIST_CONFIRMED = 5;
  localparam int CTL_KEY_CONFIRMED = 4;
  localparam int CTL_ENCRYPT_DISABLE = 3;
  localparam int CTL_ENCRYPT_ENABLE = 2;
  localparam int CTL_AUTH_DISABLE = 1;
  localparam int CTL_AUTH_ENABLE = 0;

  // Status field positions
  localparam int STS_LINK_ERROR = 7;
  localparam int STS_RX_IRQ_N = 6;
  localparam int STS_LOCK_SEEN = 5;
  localparam int STS_HOTPLUG = 4;
  localparam int STS_RX_DETECT = 3;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Encryption control mode codes
  typedef enum logic [1:0] {
    CPCSR_ENC_AUTHED = 2'h0,
    CPCSR_ENC_REG = 2'h1,
    CPCSR_ENC_ALWAYS = 2'h2,
    CPCSR_ENC_INBAND = 2'h3
  } cpcsr_enc_mode_t;

  // Video path selection, one-hot
  typedef enum logic [2:0] {
    CPCSR_VID_PLAIN = 3'h1,
    CPCSR_VID_CIPHER = 3'h2,
    CPCSR_VID_BLUE = 3'h4
  } cpcsr_video_t;

  // Commands to the protection transmitter
  typedef struct packed {
    logic tx_reset;
    logic auth_restart;
    logic auth_disable;
    logic key_list_confirmed;
    logic auth_enabled;
    logic receiver_key_confirmed;
    logic auth_pause;
  } cpcsr_cmd_t;

  // Pin levels relayed from the downstream receiver
  typedef struct packed {
    logic receiver_irq_input_pin;
    logic downstream_lock_seen;
    logic rx_detect;
  } cpcsr_link_t;

  // Engine state reported to the register pair
  typedef struct packed {
    logic link_channel_error;
    logic downstream_hotplug_event;
    logic receiver_key_ready;
    logic authenticated;
    logic is_repeater;
    logic inband_encrypt;
  } cpcsr_engine_t;

  localparam cpcsr_cmd_t CMD_RST = '0;

endpackage

// ===== src/cpcsr_sync.sv
// Two-stage synchroniser for asynchronous level inputs
module cpcsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule // cpcsr_sync

// ===== src/cpcsr_regs.sv
// Control and status register pair of the content-protection transmitter
// Summary of operation
// [R1] Control bit 7 write-one resets transmitter, disables authentication, then self-clears.
// [R2] Host sets list-confirmed bit only after checking repeater key list.
// [R3] List-confirmed bit lets authentication complete, and self-clears.
// [R4] Host sets key-confirmed bit only after checking receiver key vector.
// [R5] Key-confirmed bit clears when key-ready asserts; writing zero does nothing.
// [R6] Encrypt-disable write-one sends plain video, keeps authentication, self-clears.
// [R7] Encrypt enabled: cipher video when authenticated, blue screen otherwise. Code: register mode only; other modes ignore the bit.
// [R8] Encrypt enable cleared: video goes out without encryption. Code: register mode only; when-authenticated and in-band modes ignore the bit.
// [R9] Always-encrypt mode makes encrypt-enable read-only, reading one.
// [R10] Host should keep encryption enabled while supplying protected video.
// [R11] Control bit 1 write-one disables authentication, then self-clears.
// [R12] Control bit 0 write-one enables or restarts authentication; zero does nothing.
// [R13] Reading bit 0 returns current authentication-enabled state.
// [R14] Status bit 7 sets on link channel error, clears on status read.
// [R15] Status bit 6 mirrors downstream interrupt pin, active low.
// [R16] Status bit 5 shows downstream receiver lock.
// [R17] Status bit 4 sets on downstream hot-plug event, clears on status read.
// [R18] Status bit 3 shows downstream receiver detected.
// [R19] Two-bit mode: when-authenticated, register, always-encrypt, or per-frame in-band.
// [R20] Non-repeater with key ready pauses until key-confirmed bit is set.
// [R21] Reserved bit 6 reads zero; self-clearing bits drop after one cycle.
// [R22] Clear-on-read bits clear after the read; coincident event stays set.
module cpcsr_regs (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [cpcsr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [cpcsr_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [cpcsr_pkg::DATA_W-1:0] RDATA,
  input wire cpcsr_pkg::cpcsr_enc_mode_t ENC_MODE,
  input wire cpcsr_pkg::cpcsr_link_t LINK_PINS,
  input wire cpcsr_pkg::cpcsr_engine_t ENGINE,
  output cpcsr_pkg::cpcsr_cmd_t CMD,
  output cpcsr_pkg::cpcsr_video_t VIDEO_SEL
);

  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Pin levels from the link
  cpcsr_pkg::cpcsr_link_t link_s;

  cpcsr_sync #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_link_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .d(LINK_PINS),
    .q(link_s)
  );

  // Decode
  logic ctl_wr;
  logic sts_rd;
  logic ctl_rd;

  assign ctl_wr = WR && (ADDR == cpcsr_pkg::PROTECT_CONTROL_ADDR);
  assign ctl_rd = RD && (ADDR == cpcsr_pkg::PROTECT_CONTROL_ADDR);
  assign sts_rd = RD && (ADDR == cpcsr_pkg::PROTECT_STATUS_ADDR);

  // Control state
  logic tx_reset_reg;
  logic tx_reset_next;
  logic list_ok_reg;
  logic list_ok_next;
  logic key_ok_reg;
  logic key_ok_next;
  logic enc_dis_reg;
  logic enc_dis_next;
  logic enc_en_reg;
  logic enc_en_next;
  logic auth_dis_reg;
  logic auth_dis_next;
  logic restart_reg;
  logic restart_next;
  logic auth_en_reg;
  logic auth_en_next;
  logic key_ready_d_reg;
  logic key_ready_d_next;
  logic key_ready_rise;
  logic enc_en_eff;

  assign key_ready_rise = ENGINE.receiver_key_ready && !key_ready_d_reg;
  assign enc_en_eff = (ENC_MODE == cpcsr_pkg::CPCSR_ENC_ALWAYS) ? 1'b1 : enc_en_reg; // R9

  always_comb
  begin
    // Self-clearing bits are single-cycle pulses
    tx_reset_next = ctl_wr && WDATA[cpcsr_pkg::CTL_TX_RESET]; // R1 R21
    list_ok_next = ctl_wr && WDATA[cpcsr_pkg::CTL_LIST_CONFIRMED]; // R3 R21
    enc_dis_next = ctl_wr && WDATA[cpcsr_pkg::CTL_ENCRYPT_DISABLE]; // R6 R21
    auth_dis_next = ctl_wr && WDATA[cpcsr_pkg::CTL_AUTH_DISABLE]; // R11 R21
    restart_next = ctl_wr && WDATA[cpcsr_pkg::CTL_AUTH_ENABLE]; // R12
    key_ready_d_next = ENGINE.receiver_key_ready;

    // Authentication enabled state
    auth_en_next = auth_en_reg;
    if (tx_reset_reg || auth_dis_reg)
    begin
      auth_en_next = 1'b0; // R1 R11
    end
    if (restart_reg)
    begin
      auth_en_next = 1'b1; // R12
    end

    // Key confirmed: cleared by key-ready rise, write of one wins
    key_ok_next = key_ok_reg;
    if (key_ready_rise || tx_reset_reg)
    begin
      key_ok_next = 1'b0; // R5
    end
    if (ctl_wr && WDATA[cpcsr_pkg::CTL_KEY_CONFIRMED])
    begin
      key_ok_next = 1'b1; // R5
    end

    // Encrypt enable: a following host write wins over the disable pulse
    enc_en_next = enc_en_reg;
    if (enc_dis_reg)
    begin
      enc_en_next = 1'b0; // R6
    end
    if (ctl_wr && (ENC_MODE != cpcsr_pkg::CPCSR_ENC_ALWAYS))
    begin
      enc_en_next = WDATA[cpcsr_pkg::CTL_ENCRYPT_ENABLE]; // R9
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_reset_reg <= 1'b0;
      list_ok_reg <= 1'b0;
      key_ok_reg <= 1'b0;
      enc_dis_reg <= 1'b0;
      enc_en_reg <= 1'b0;
      auth_dis_reg <= 1'b0;
      restart_reg <= 1'b0;
      auth_en_reg <= 1'b0;
      key_ready_d_reg <= 1'b0;
    end
    else
    begin
      tx_reset_reg <= tx_reset_next;
      list_ok_reg <= list_ok_next;
      key_ok_reg <= key_ok_next;
      enc_dis_reg <= enc_dis_next;
      enc_en_reg <= enc_en_next;
      auth_dis_reg <= auth_dis_next;
      restart_reg <= restart_next;
      auth_en_reg <= auth_en_next;
      key_ready_d_reg <= key_ready_d_next;
    end
  end

  // Status sticky bits
  logic err_reg;
  logic err_next;
  logic hpd_reg;
  logic hpd_next;

  always_comb
  begin
    err_next = err_reg;
    hpd_next = hpd_reg;
    if (sts_rd)
    begin
      err_next = 1'b0; // R14 R22
      hpd_next = 1'b0; // R17 R22
    end
    if (ENGINE.link_channel_error)
    begin
      err_next = 1'b1; // R14 R22
    end
    if (ENGINE.downstream_hotplug_event)
    begin
      hpd_next = 1'b1; // R17 R22
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_reg <= 1'b0;
      hpd_reg <= 1'b0;
    end
    else
    begin
      err_reg <= err_next;
      hpd_reg <= hpd_next;
    end
  end

  // Read path
  logic [cpcsr_pkg::DATA_W-1:0] ctl_view;
  logic [cpcsr_pkg::DATA_W-1:0] sts_view;
  logic [cpcsr_pkg::DATA_W-1:0] rdata_reg;
  logic [cpcsr_pkg::DATA_W-1:0] rdata_next;

  always_comb
  begin
    ctl_view = cpcsr_pkg::PROTECT_CONTROL_RST;
    ctl_view[cpcsr_pkg::CTL_TX_RESET] = tx_reset_reg;
    ctl_view[cpcsr_pkg::CTL_RESERVED] = 1'b0; // R21
    ctl_view[cpcsr_pkg::CTL_LIST_CONFIRMED] = list_ok_reg;
    ctl_view[cpcsr_pkg::CTL_KEY_CONFIRMED] = key_ok_reg;
    ctl_view[cpcsr_pkg::CTL_ENCRYPT_DISABLE] = enc_dis_reg;
    ctl_view[cpcsr_pkg::CTL_ENCRYPT_ENABLE] = enc_en_eff; // R9
    ctl_view[cpcsr_pkg::CTL_AUTH_DISABLE] = auth_dis_reg;
    ctl_view[cpcsr_pkg::CTL_AUTH_ENABLE] = auth_en_reg; // R13

    sts_view = cpcsr_pkg::PROTECT_STATUS_RST;
    sts_view[cpcsr_pkg::STS_LINK_ERROR] = err_reg; // R14
    sts_view[cpcsr_pkg::STS_RX_IRQ_N] = link_s.receiver_irq_input_pin; // R15
    sts_view[cpcsr_pkg::STS_LOCK_SEEN] = link_s.downstream_lock_seen; // R16
    sts_view[cpcsr_pkg::STS_HOTPLUG] = hpd_reg; // R17
    sts_view[cpcsr_pkg::STS_RX_DETECT] = link_s.rx_detect; // R18

    rdata_next = cpcsr_pkg::READ_IDLE;
    if (ctl_rd)
    begin
      rdata_next = ctl_view;
    end
    else if (sts_rd)
    begin
      rdata_next = sts_view;
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= cpcsr_pkg::READ_IDLE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  // Video path and command outputs
  cpcsr_pkg::cpcsr_video_t video_reg;
  cpcsr_pkg::cpcsr_video_t video_next;
  cpcsr_pkg::cpcsr_cmd_t cmd_reg;
  cpcsr_pkg::cpcsr_cmd_t cmd_next;
  logic want_cipher;

  always_comb
  begin
    unique case (ENC_MODE) // R19
      cpcsr_pkg::CPCSR_ENC_AUTHED: want_cipher = ENGINE.authenticated;
      cpcsr_pkg::CPCSR_ENC_REG: want_cipher = enc_en_eff;
      cpcsr_pkg::CPCSR_ENC_ALWAYS: want_cipher = 1'b1;
      cpcsr_pkg::CPCSR_ENC_INBAND: want_cipher = ENGINE.inband_encrypt;
    endcase

    if (!want_cipher || enc_dis_reg)
    begin
      video_next = cpcsr_pkg::CPCSR_VID_PLAIN; // R6 R8
    end
    else if (ENGINE.authenticated)
    begin
      video_next = cpcsr_pkg::CPCSR_VID_CIPHER; // R7
    end
    else if (ENC_MODE == cpcsr_pkg::CPCSR_ENC_AUTHED)
    begin
      video_next = cpcsr_pkg::CPCSR_VID_PLAIN;
    end
    else
    begin
      video_next = cpcsr_pkg::CPCSR_VID_BLUE; // R7
    end

    cmd_next.tx_reset = tx_reset_reg; // R1
    cmd_next.auth_restart = restart_reg; // R12
    cmd_next.auth_disable = auth_dis_reg || tx_reset_reg; // R11
    cmd_next.key_list_confirmed = list_ok_reg; // R3
    cmd_next.auth_enabled = auth_en_next; // R13
    cmd_next.receiver_key_confirmed = key_ok_next;
    cmd_next.auth_pause = ENGINE.receiver_key_ready && !ENGINE.is_repeater && !key_ok_next; // R20
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      video_reg <= cpcsr_pkg::CPCSR_VID_PLAIN;
      cmd_reg <= cpcsr_pkg::CMD_RST;
    end
    else
    begin
      video_reg <= video_next;
      cmd_reg <= cmd_next;
    end
  end

  assign VIDEO_SEL = video_reg;
  assign CMD = cmd_reg;

endmodule // cpcsr_regs

// ===== tb/cpcsr_regs_monitor.sv
// Assertion checker on the register pair ports
module cpcsr_regs_monitor (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire cpcsr_pkg::cpcsr_enc_mode_t ENC_MODE,
  input wire cpcsr_pkg::cpcsr_link_t LINK_PINS,
  input wire cpcsr_pkg::cpcsr_engine_t ENGINE,
  input wire cpcsr_pkg::cpcsr_cmd_t CMD,
  input wire cpcsr_pkg::cpcsr_video_t VIDEO_SEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_ctl_rd;
    RD && ADDR == 8'hc3;
  endsequence
  sequence s_sts_rd;
    RD && ADDR == 8'hc4;
  endsequence
  sequence s_ctl_wr(int b);
    WR && ADDR == 8'hc3 && WDATA[b];
  endsequence
  chk_rsvd_zero: assert property (s_ctl_rd |=> !RDATA[6])
    else $error("reserved bit read as one");
  chk_always_one: assert property ((s_ctl_rd ##0 ENC_MODE == cpcsr_pkg::CPCSR_ENC_ALWAYS) |=> RDATA[2])
    else $error("encrypt enable not one in always mode");
  chk_reset_cmd: assert property (s_ctl_wr(7) |-> ##[1:3] CMD.tx_reset)
    else $error("no transmitter reset");
  chk_restart_cmd: assert property (s_ctl_wr(0) |-> ##[1:3] CMD.auth_restart)
    else $error("no restart");
  chk_disable_cmd: assert property (s_ctl_wr(1) |-> ##[1:3] CMD.auth_disable)
    else $error("no auth disable");
  chk_list_cmd: assert property (s_ctl_wr(5) |-> ##[1:3] CMD.key_list_confirmed)
    else $error("no list confirm");
  chk_plain_cmd: assert property (s_ctl_wr(3) |-> ##[1:3] VIDEO_SEL == cpcsr_pkg::CPCSR_VID_PLAIN)
    else $error("video not plain");
  chk_err_seen: assert property (ENGINE.link_channel_error ##1 !RD ##1 s_sts_rd |=> RDATA[7])
    else $error("link error lost");
  chk_hpd_seen: assert property (ENGINE.downstream_hotplug_event ##1 !RD ##1 s_sts_rd |=> RDATA[4])
    else $error("hotplug lost");
  chk_pulse_short: assert property (CMD.tx_reset |=> !CMD.tx_reset)
    else $error("reset pulse too long");
endmodule // cpcsr_regs_monitor

// ===== tb/cpcsr_far.sv
// Downstream receiver model feeding engine state
module cpcsr_far (
  input wire logic clk,
  input wire logic rst_n,
  input wire cpcsr_pkg::cpcsr_cmd_t cmd,
  input wire logic ev_err,
  input wire logic ev_hpd,
  input wire logic key_rdy,
  input wire logic inband,
  output cpcsr_pkg::cpcsr_engine_t engine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic auth_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auth_reg <= 1'b0;
    else
      auth_reg <= cmd.auth_enabled && !cmd.auth_pause && !cmd.auth_restart;
  end
  assign engine = {ev_err, ev_hpd, key_rdy, auth_reg, 1'b0, inband};
endmodule // cpcsr_far

// ===== tb/cpcsr_regs_test.sv
// Testbench for the protection register pair
module cpcsr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] C = cpcsr_pkg::PROTECT_CONTROL_ADDR;
  localparam logic [7:0] S = cpcsr_pkg::PROTECT_STATUS_ADDR;
  logic CLK, NRST, WR, RD, ev_err, ev_hpd, key_rdy, inband;
  logic [7:0] ADDR, WDATA, RDATA;
  cpcsr_pkg::cpcsr_enc_mode_t ENC_MODE;
  cpcsr_pkg::cpcsr_link_t LINK_PINS;
  cpcsr_pkg::cpcsr_engine_t ENGINE;
  cpcsr_pkg::cpcsr_cmd_t CMD;
  cpcsr_pkg::cpcsr_video_t VIDEO_SEL;
  int fail_count = 0;
  int n_checks = 0;
  cpcsr_regs i_cpcsr_regs (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ENC_MODE(ENC_MODE), .LINK_PINS(LINK_PINS), .ENGINE(ENGINE), .CMD(CMD),
    .VIDEO_SEL(VIDEO_SEL));
  cpcsr_far i_cpcsr_far (.clk(CLK), .rst_n(NRST), .cmd(CMD), .ev_err(ev_err), .ev_hpd(ev_hpd),
    .key_rdy(key_rdy), .inband(inband), .engine(ENGINE));
  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk(n, e, RDATA);
  endtask
  task automatic vid(input cpcsr_pkg::cpcsr_video_t e);
    repeat (6) @(negedge CLK);
    chk("video", {5'h00, e}, {5'h00, VIDEO_SEL});
  endtask
  task automatic t_reset;
    rc(C, 8'h00, "ctl");
    rc(S, 8'h40, "sts");
    rc(8'hc5, 8'h00, "unmapped");
  endtask
  task automatic t_auth;
    wr(C, 8'h01);
    rc(C, 8'h01, "ctl");
    wr(C, 8'h00);
    rc(C, 8'h01, "ctl");
    wr(C, 8'h02);
    rc(C, 8'h00, "ctl");
    wr(C, 8'h21);
    wr(C, 8'h80);
    rc(C, 8'h00, "ctl");
    wr(C, 8'h40);
    rc(C, 8'h00, "ctl");
  endtask
  task automatic t_enc;
    @(posedge CLK);
    ENC_MODE <= cpcsr_pkg::CPCSR_ENC_REG;
    wr(C, 8'h04);
    vid(cpcsr_pkg::CPCSR_VID_BLUE);
    wr(C, 8'h08);
    rc(C, 8'h00, "ctl");
    vid(cpcsr_pkg::CPCSR_VID_PLAIN);
    @(posedge CLK);
    ENC_MODE <= cpcsr_pkg::CPCSR_ENC_ALWAYS;
    wr(C, 8'h00);
    rc(C, 8'h04, "ctl");
    @(posedge CLK);
    ENC_MODE <= cpcsr_pkg::CPCSR_ENC_AUTHED;
    wr(C, 8'h01);
    vid(cpcsr_pkg::CPCSR_VID_CIPHER);
    wr(C, 8'h08);
    rc(C, 8'h01, "ctl");
    @(posedge CLK);
    ENC_MODE <= cpcsr_pkg::CPCSR_ENC_INBAND;
    inband <= 1'b1;
    vid(cpcsr_pkg::CPCSR_VID_CIPHER);
    @(posedge CLK);
    inband <= 1'b0;
    vid(cpcsr_pkg::CPCSR_VID_PLAIN);
    wr(C, 8'h02);
  endtask
  task automatic t_key;
    wr(C, 8'h10);
    rc(C, 8'h10, "ctl");
    wr(C, 8'h00);
    rc(C, 8'h10, "ctl");
    @(posedge CLK);
    key_rdy <= 1'b1;
    repeat (3) @(negedge CLK);
    chk("pause", 8'h01, {7'h00, CMD.auth_pause});
    rc(C, 8'h00, "ctl");
    wr(C, 8'h10);
    @(negedge CLK);
    chk("pause", 8'h00, {7'h00, CMD.auth_pause});
    @(posedge CLK);
    key_rdy <= 1'b0;
  endtask
  task automatic t_sts;
    @(posedge CLK);
    ev_err <= 1'b1;
    @(posedge CLK);
    ev_err <= 1'b0;
    rc(S, 8'hc0, "sts");
    rc(S, 8'h40, "sts");
    @(posedge CLK);
    ev_hpd <= 1'b1;
    @(posedge CLK);
    ev_hpd <= 1'b0;
    rc(S, 8'h50, "sts");
    rc(S, 8'h40, "sts");
    @(posedge CLK);
    LINK_PINS <= 3'h3;
    repeat (4) @(posedge CLK);
    rc(S, 8'h28, "sts");
    @(posedge CLK);
    ev_err <= 1'b1;
    RD <= 1'b1;
    ADDR <= S;
    @(posedge CLK);
    ev_err <= 1'b0;
    RD <= 1'b0;
    @(negedge CLK);
    chk("sts", 8'h28, RDATA);
    rc(S, 8'ha8, "sts");
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial
  begin
    repeat (3000) @(posedge CLK);
    fail_count++;
    summarize();
  end
  initial
  begin
    NRST = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    ENC_MODE = cpcsr_pkg::CPCSR_ENC_AUTHED;
    LINK_PINS = 3'h4;
    ev_err = 1'b0;
    ev_hpd = 1'b0;
    key_rdy = 1'b0;
    inband = 1'b0;
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset();
    t_auth();
    t_enc();
    t_key();
    t_sts();
    summarize();
  end
endmodule // cpcsr_regs_test
bind cpcsr_regs cpcsr_regs_monitor i_cpcsr_regs_monitor (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .ENC_MODE(ENC_MODE), .LINK_PINS(LINK_PINS), .ENGINE(ENGINE), .CMD(CMD),
  .VIDEO_SEL(VIDEO_SEL));
